// ### logic/dual_timer_capture_reload.sv
// Dual up/down timer with toggle latch, capture/reload register and Wishbone slave
`timescale 1ns/10ps
`include "gpt_map.svh"
module dual_timer_capture_reload
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_aux_count_pin,
	input wire logic i_core_count_pin,
	input wire logic i_aux_direction_pin,
	input wire logic i_core_direction_pin,
	input wire logic i_capture_in_pin,
	input wire logic i_peer_count_input,
	input wire logic i_peer_direction_input,
	output logic o_toggle_out_pin,
	output logic o_core_wrap_event,
	output logic o_irq
);
	import gpt_pkg::*;

	// Byte-lane merge of a 16-bit register with write data
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Byte-lane merge of a control register; a slice of a call result is not legal
	function automatic logic [`CTL_W-1:0] merge_ctl(input logic [`CTL_W-1:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		merge_ctl = {sel[1] ? wd[`CTL_W-1:8] : old[`CTL_W-1:8], sel[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Prescaler hit: low sel bits of the prescale count all ones
	function automatic logic presc_hit(input logic [`PRE_W-1:0] pc, input logic [2:0] sel);
		logic [`PRE_W-1:0] m;
		m = ~(8'hff << sel);
		presc_hit = (pc & m) == m;
	endfunction

	// Edge match on a synchronised level
	function automatic logic edge_hit(input logic prev, input logic cur, input edge_t e);
		edge_hit = ((e == EDGE_RISE || e == EDGE_BOTH) && !prev && cur)
			|| ((e == EDGE_FALL || e == EDGE_BOTH) && prev && !cur);
	endfunction

	timer_if aux (); // Auxiliary timer bundle
	timer_if core (); // Core timer bundle

	gpt_timer_unit u_aux (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .tmr(aux));
	gpt_timer_unit u_core (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .tmr(core));

	// Input synchronisers: stage one feeds stage two only
	logic [`PIN_N-1:0] pin_raw;
	logic [`PIN_N-1:0] sync1;
	logic [`PIN_N-1:0] sync2; // Synchronised levels
	logic [`PIN_N-1:0] sync3; // Previous level, for edges
	assign pin_raw = {i_peer_direction_input, i_peer_count_input, i_capture_in_pin,
		i_core_direction_pin, i_aux_direction_pin, i_core_count_pin, i_aux_count_pin};

	// Synchroniser chain
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sync1 <= `PIN_RST;
			sync2 <= `PIN_RST;
			sync3 <= `PIN_RST;
		end
		else
		begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Timing state
	logic base_tick, next_base_tick; // Half-rate step enable
	logic [`PRE_W-1:0] pcnt, next_pcnt; // Shared prescale counter
	logic tl, next_tl; // Core toggle latch
	logic tl_q, next_tl_q; // Latch delayed, to spot changes
	logic tog_out, next_tog_out;
	logic wrap_out, next_wrap_out;

	// Control and data registers
	logic [`CTL_W-1:0] ctl_aux, next_ctl_aux;
	logic [`CTL_W-1:0] ctl_core, next_ctl_core;
	logic [`TMR_W-1:0] capture_reload_reg, next_capture_reload_reg;
	logic [`ST_W-1:0] status, next_status;
	logic [`ST_W-1:0] mask, next_mask;
	bus_state_t bus_st, next_bus_st;
	logic [31:0] rdat, next_rdat;

	// Decoded fields
	clk_src_t aux_src, core_src;
	cap_src_t cap_src;
	edge_t cap_edge;
	logic req; // Bus request present
	logic wr_go; // Write takes effect at this edge
	logic [7:0] adr_w; // Word-aligned address
	logic aux_cnt_wr, core_cnt_wr;
	logic cap_hit; // Capture trigger this cycle
	logic latch_chg; // Toggle latch changed last cycle
	logic aux_step, core_step;

	assign aux_src = clk_src_t'(ctl_aux[`CTL_SRC_HI:`CTL_SRC_LO]);
	assign core_src = clk_src_t'({1'b0, ctl_core[`CTL_SRC_LO]});
	assign cap_src = cap_src_t'(ctl_aux[`CTL_CAPSRC_HI:`CTL_CAPSRC_LO]);
	assign cap_edge = edge_t'(ctl_aux[`CTL_EDGE_HI:`CTL_EDGE_LO]);
	assign req = i_wb_cyc && i_wb_stb;
	assign wr_go = req && i_wb_we && (bus_st == BUS_ACK);
	assign adr_w = {i_wb_adr[7:2], 2'b00};
	assign aux_cnt_wr = wr_go && (adr_w == `OFS_AUX_CNT);
	assign core_cnt_wr = wr_go && (adr_w == `OFS_CORE_CNT);
	assign latch_chg = tl != tl_q;

	// Count enables per clock source, all no faster than the half-rate tick
	always_comb
	begin
		case (aux_src)
			SRC_PRESC: aux_step = base_tick && presc_hit(pcnt, ctl_aux[`CTL_PRE_HI:`CTL_PRE_LO]);
			SRC_EXT: aux_step = !sync3[`PIN_AUX_CNT] && sync2[`PIN_AUX_CNT];
			SRC_LATCH: aux_step = latch_chg;
			default: aux_step = 1'b0;
		endcase
		case (core_src)
			SRC_PRESC: core_step = base_tick && presc_hit(pcnt, ctl_core[`CTL_PRE_HI:`CTL_PRE_LO]);
			SRC_EXT: core_step = !sync3[`PIN_CORE_CNT] && sync2[`PIN_CORE_CNT];
			default: core_step = 1'b0;
		endcase
	end

	// Capture trigger: pin or peer inputs, on the chosen edge
	always_comb
	begin
		case (cap_src)
			CAP_PIN: cap_hit = edge_hit(sync3[`PIN_CAPTURE_IN_PIN], sync2[`PIN_CAPTURE_IN_PIN], cap_edge);
			CAP_PEER_CNT: cap_hit = edge_hit(sync3[`PIN_PEER_CNT], sync2[`PIN_PEER_CNT],
				cap_edge);
			CAP_PEER_DIR: cap_hit = edge_hit(sync3[`PIN_PEER_DIR], sync2[`PIN_PEER_DIR],
				cap_edge);
			CAP_PEER_BOTH: cap_hit = edge_hit(sync3[`PIN_PEER_CNT], sync2[`PIN_PEER_CNT], cap_edge)
				|| edge_hit(sync3[`PIN_PEER_DIR], sync2[`PIN_PEER_DIR], cap_edge);
			default: cap_hit = 1'b0;
		endcase
	end

	// Timer drive: direction, steps, loads with software first
	always_comb
	begin
		aux.count_en = ctl_aux[`CTL_RUN] && aux_step;
		core.count_en = ctl_core[`CTL_RUN] && core_step;
		// Direction bit set means down; a high direction pin inverts it
		aux.up = !(ctl_aux[`CTL_DIR] ^ (ctl_aux[`CTL_DPIN] && sync2[`PIN_AUX_DIR]));
		core.up = !(ctl_core[`CTL_DIR] ^ (ctl_core[`CTL_DPIN] && sync2[`PIN_CORE_DIR]));
		aux.load = aux_cnt_wr || (cap_hit && ctl_aux[`CTL_CLRCAP]);
		aux.load_val = aux_cnt_wr ? merge16(aux.cnt, i_wb_dat, i_wb_sel) : `TMR_ZERO;
		// Reload replaces the wrapping step in the same cycle
		core.load = core_cnt_wr || (core.wrap && ctl_core[`CTL_RELOAD]);
		core.load_val = core_cnt_wr ? merge16(core.cnt, i_wb_dat, i_wb_sel) : capture_reload_reg;
	end

	// Next values of timing, control and bus state
	always_comb
	begin
		next_base_tick = !base_tick;
		next_pcnt = base_tick ? pcnt + 8'h01 : pcnt;
		next_tl = tl ^ core.wrap;
		next_tl_q = tl;
		next_tog_out = tl && ctl_core[`CTL_TOGOUT];
		next_wrap_out = core.wrap;
		next_ctl_aux = ctl_aux;
		next_ctl_core = ctl_core;
		next_capture_reload_reg = capture_reload_reg;
		next_mask = mask;
		next_status = status;
		next_rdat = rdat;
		next_bus_st = BUS_IDLE;
		// Writes act at the edge where ack is high
		if (wr_go)
		begin
			case (adr_w)
				`OFS_AUX_CTRL: next_ctl_aux = merge_ctl(ctl_aux, i_wb_dat, i_wb_sel)
					& `AUX_CTL_MASK;
				`OFS_CORE_CTRL: next_ctl_core = merge_ctl(ctl_core, i_wb_dat, i_wb_sel)
					& `CORE_CTL_MASK;
				`OFS_CAPTURE_RELOAD_REG: next_capture_reload_reg = merge16(capture_reload_reg, i_wb_dat, i_wb_sel);
				`OFS_STATUS: next_status = status & ~(i_wb_sel[0] ? i_wb_dat[`ST_W-1:0]
					: `ST_RST);
				`OFS_MASK: next_mask = i_wb_sel[0] ? i_wb_dat[`ST_W-1:0] : mask;
				default: next_mask = mask; // Unmapped writes are dropped
			endcase
		end
		// Hardware capture beats a software write in the same cycle
		if (cap_hit)
		begin
			next_capture_reload_reg = aux.cnt;
		end
		// Events set status after any clear, so a set wins
		next_status = next_status | {cap_hit, core.wrap, aux.wrap};
		// One-cycle answer: read data latched with ack
		case (bus_st)
			BUS_IDLE:
			begin
				if (req)
				begin
					next_bus_st = BUS_ACK;
					case (adr_w)
						`OFS_AUX_CTRL: next_rdat = {19'h0, ctl_aux};
						`OFS_CORE_CTRL: next_rdat = {19'h0, ctl_core};
						`OFS_AUX_CNT: next_rdat = {16'h0, aux.cnt};
						`OFS_CORE_CNT: next_rdat = {16'h0, core.cnt};
						`OFS_CAPTURE_RELOAD_REG: next_rdat = {16'h0, capture_reload_reg};
						`OFS_STATUS: next_rdat = {29'h0, status};
						`OFS_MASK: next_rdat = {29'h0, mask};
						default: next_rdat = 32'h0000_0000; // Unmapped reads zero
					endcase
				end
			end
			BUS_ACK: next_bus_st = BUS_IDLE; // Ack lasts one cycle
			default: next_bus_st = BUS_IDLE;
		endcase
	end

	// Register all state
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			base_tick <= 1'b0;
			pcnt <= `PRE_RST;
			tl <= 1'b0;
			tl_q <= 1'b0;
			tog_out <= 1'b0;
			wrap_out <= 1'b0;
			ctl_aux <= `CTL_RST;
			ctl_core <= `CTL_RST;
			capture_reload_reg <= `TMR_ZERO;
			status <= `ST_RST;
			mask <= `ST_RST;
			rdat <= 32'h0000_0000;
			bus_st <= BUS_IDLE;
		end
		else
		begin
			base_tick <= next_base_tick;
			pcnt <= next_pcnt;
			tl <= next_tl;
			tl_q <= next_tl_q;
			tog_out <= next_tog_out;
			wrap_out <= next_wrap_out;
			ctl_aux <= next_ctl_aux;
			ctl_core <= next_ctl_core;
			capture_reload_reg <= next_capture_reload_reg;
			status <= next_status;
			mask <= next_mask;
			rdat <= next_rdat;
			bus_st <= next_bus_st;
		end
	end

	// Outputs
	assign o_wb_ack = bus_st == BUS_ACK;
	assign o_wb_dat = rdat;
	assign o_toggle_out_pin = tog_out;
	assign o_core_wrap_event = wrap_out;
	assign o_irq = |(status & mask);

	core_step_gap_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		core.count_en && core_src == SRC_PRESC |=> !core.count_en)
		else $error("core timer stepped twice in a row");
	aux_dir_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ctl_aux[`CTL_DPIN] && sync2[`PIN_AUX_DIR] |-> aux.up == ctl_aux[`CTL_DIR])
		else $error("direction pin ignored");
	toggle_flip_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		core.wrap |=> tl != $past(tl))
		else $error("toggle latch did not flip");
	toggle_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ctl_core[`CTL_TOGOUT] ##1 ctl_core[`CTL_TOGOUT] |-> o_toggle_out_pin == $past(tl))
		else $error("toggle pin does not follow latch");
	wrap_export_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		core.wrap |=> o_core_wrap_event ##1 !$past(core.wrap) || o_core_wrap_event)
		else $error("core wrap not exported");
	reload_now_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		core.wrap && ctl_core[`CTL_RELOAD] && !core_cnt_wr |=> core.cnt == $past(capture_reload_reg))
		else $error("core reload missed");
	capture_copy_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		cap_hit |=> capture_reload_reg == $past(aux.cnt) && status[`ST_CAPTURE])
		else $error("capture value wrong");
	clear_after_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		cap_hit && ctl_aux[`CTL_CLRCAP] && !aux_cnt_wr |=> aux.cnt == `TMR_ZERO)
		else $error("aux timer not cleared");
	peer_trigger_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		cap_src == CAP_PEER_CNT && cap_edge == EDGE_RISE && !sync3[`PIN_PEER_CNT]
		&& sync2[`PIN_PEER_CNT] |-> cap_hit)
		else $error("peer count edge did not capture");
	sync_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(sync1[`PIN_CAPTURE_IN_PIN]) |=> $rose(sync2[`PIN_CAPTURE_IN_PIN]))
		else $error("synchroniser delay wrong");
	bus_ack_once_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_wb_ack |=> !o_wb_ack)
		else $error("ack held too long");
endmodule

// ### logic/gpt_map.svh
// Register offsets, field positions and reset values of the dual timer
// How it works
// - Timers advance at most every second cycle
// - Each timer: prescaled clock or external events
// - Direction from software bit or direction pin
// - Core toggle latch flips on every wrap
// - Latch clocks aux timer, optionally drives pin
// - Core wraps exported to compare unit timers
// - Core wrap reloads from capture/reload register
// - Capture pin edge copies aux count
// - Optionally clear aux timer after capture
// - Peer timer inputs may trigger the capture
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH
// Word offsets on the register bus
`define OFS_AUX_CTRL 8'h00
`define OFS_CORE_CTRL 8'h04
`define OFS_AUX_CNT 8'h08
`define OFS_CORE_CNT 8'h0c
`define OFS_CAPTURE_RELOAD_REG 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18
// Control register fields (both timers share the low layout)
`define CTL_W 13
`define CTL_RUN 0
`define CTL_DIR 1
`define CTL_DPIN 2
`define CTL_SRC_LO 3
`define CTL_SRC_HI 4
`define CTL_PRE_LO 5
`define CTL_PRE_HI 7
`define CTL_CLRCAP 8
`define CTL_RELOAD 8
`define CTL_CAPSRC_LO 9
`define CTL_CAPSRC_HI 10
`define CTL_TOGOUT 9
`define CTL_EDGE_LO 11
`define CTL_EDGE_HI 12
`define AUX_CTL_MASK 13'h1fff
`define CORE_CTL_MASK 13'h03ef
`define CTL_RST 13'h0000
// Status and mask bits
`define ST_W 3
`define ST_AUX_WRAP 0
`define ST_CORE_WRAP 1
`define ST_CAPTURE 2
`define ST_RST 3'h0
// Timer and prescaler sizes
`define TMR_W 16
`define TMR_MAX 16'hffff
`define TMR_ZERO 16'h0000
`define PRE_W 8
`define PRE_RST 8'h00
// Synchronised pin vector positions
`define PIN_N 7
`define PIN_AUX_CNT 0
`define PIN_CORE_CNT 1
`define PIN_AUX_DIR 2
`define PIN_CORE_DIR 3
`define PIN_CAPTURE_IN_PIN 4
`define PIN_PEER_CNT 5
`define PIN_PEER_DIR 6
`define PIN_RST 7'h00
`endif

// ### logic/gpt_pkg.sv
// Types shared by the dual timer modules
package gpt_pkg;
	// Count clock source of a timer
	typedef enum logic [1:0] {SRC_PRESC = 2'b00, SRC_EXT = 2'b01, SRC_LATCH = 2'b10,
		SRC_OFF = 2'b11} clk_src_t;
	// Capture trigger source
	typedef enum logic [1:0] {CAP_PIN = 2'b00, CAP_PEER_CNT = 2'b01, CAP_PEER_DIR = 2'b10,
		CAP_PEER_BOTH = 2'b11} cap_src_t;
	// Capture edge selection
	typedef enum logic [1:0] {EDGE_NONE = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11} edge_t;
	// Bus answer state
	typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_state_t;
endpackage

// ### logic/gpt_timer_unit.sv
// One 16-bit up/down timer with load and wrap detection
`timescale 1ns/10ps
`include "gpt_map.svh"
module gpt_timer_unit
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	timer_if.unit tmr
);
	import gpt_pkg::*;

	logic [`TMR_W-1:0] cnt; // Count register
	logic [`TMR_W-1:0] next_cnt; // Its next value

	// Wrap is the step that leaves the range; a load in that cycle still reports it
	assign tmr.wrap = tmr.count_en && (tmr.up ? (cnt == `TMR_MAX) : (cnt == `TMR_ZERO));
	assign tmr.cnt = cnt;

	// Next count: load first, then a step
	always_comb
	begin
		next_cnt = cnt;
		if (tmr.load)
		begin
			next_cnt = tmr.load_val;
		end
		else if (tmr.count_en)
		begin
			next_cnt = tmr.up ? cnt + 16'h0001 : cnt - 16'h0001;
		end
	end

	// Count register
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			cnt <= `TMR_ZERO;
		else
			cnt <= next_cnt;
	end

	count_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		tmr.count_en && !tmr.load |=> cnt == ($past(tmr.up) ? $past(cnt) + 16'h0001
		: $past(cnt) - 16'h0001))
		else $error("timer did not step by one");
	load_wins_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		tmr.load |=> cnt == $past(tmr.load_val))
		else $error("timer load not taken");
endmodule

// ### logic/timer_if.sv
// Control and status bundle between the top and one timer unit
`timescale 1ns/10ps
`include "gpt_map.svh"
interface timer_if;
	logic count_en; // One count step this cycle
	logic up; // Direction of the step
	logic load; // Load wins over counting
	logic [`TMR_W-1:0] load_val; // Value to load
	logic [`TMR_W-1:0] cnt; // Current count
	logic wrap; // Overflow or underflow this cycle
	modport ctrl (output count_en, output up, output load, output load_val,
		input cnt, input wrap);
	modport unit (input count_en, input up, input load, input load_val,
		output cnt, output wrap);
endinterface

// ### verification/dual_timer_capture_reload_tb.sv
// Self-checking bench for the dual timer with capture/reload
`timescale 1ns/10ps
`include "gpt_map.svh"
module dual_timer_capture_reload_tb;
	import gpt_pkg::*;
	// One capture trial: source, edge, pin to flip, capture expected, clear enabled
	typedef struct {cap_src_t src; edge_t edg; int pin; logic hit; logic clr;} cap_case_t;
	logic clk_sys;
	logic nrst;
	logic cyc, stb, we;
	logic [7:0] adr;
	logic [31:0] wdat;
	logic [3:0] sel;
	logic [31:0] o_wb_dat;
	logic o_wb_ack, o_toggle_out_pin, o_core_wrap_event, o_irq;
	logic [`PIN_N-1:0] toggle;
	logic [`PIN_N-1:0] pins;
	int ncyc = 0;
	int t_ack;
	int num_errors = 0;
	int num_checks = 0;
	// Clock, 25 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Cycle stamp for rate measurements
	always @(posedge clk_sys) ncyc <= ncyc + 1;
	event_source u_src (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_toggle(toggle), .o_pins(pins));
	dual_timer_capture_reload u_dut (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_aux_count_pin(pins[`PIN_AUX_CNT]),
		.i_core_count_pin(pins[`PIN_CORE_CNT]), .i_aux_direction_pin(pins[`PIN_AUX_DIR]),
		.i_core_direction_pin(pins[`PIN_CORE_DIR]), .i_capture_in_pin(pins[`PIN_CAPTURE_IN_PIN]),
		.i_peer_count_input(pins[`PIN_PEER_CNT]), .i_peer_direction_input(pins[`PIN_PEER_DIR]),
		.o_toggle_out_pin(o_toggle_out_pin), .o_core_wrap_event(o_core_wrap_event),
		.o_irq(o_irq));
	// Verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
		begin
			$display("RESULT: PASS");
		end
		else
		begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	// Classic single cycle; request held until ack is sampled high
	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (o_wb_ack !== 1'b1 && n < 20);
		rd = o_wb_dat;
		t_ack = ncyc;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
		begin
			num_errors++;
			$display("[FAIL] %0t bus answer missing", $time);
			report_and_stop();
		end
	endtask
	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		wb_xfer(1'b1, a, d, unused);
	endtask
	task automatic wb_rd(input logic [7:0] a, output logic [31:0] d);
		wb_xfer(1'b0, a, 32'h0, d);
	endtask
	// Flip one pin, then leave time for sync and landing
	task automatic pin_toggle(input int idx);
		@(posedge clk_sys);
		toggle <= 7'h01 << idx;
		@(posedge clk_sys);
		toggle <= '0;
		repeat (6) @(posedge clk_sys);
	endtask
	// Reset values, unmapped place, read-only control bits
	task automatic t_map;
		logic [31:0] v;
		for (int a = 0; a <= 8'h1c; a += 4)
		begin
			wb_rd(8'(a), v);
			check(v, 32'h0, "reset or unmapped value");
		end
		wb_wr(8'h1c, 32'hffffffff);
		wb_rd(8'h1c, v);
		check(v, 32'h0, "unmapped write");
		wb_wr(`OFS_CORE_CTRL, 32'h00001ee0);
		wb_rd(`OFS_CORE_CTRL, v);
		check(v, 32'h000002e0, "core ctrl mask");
		wb_wr(`OFS_CORE_CTRL, 32'h0);
	endtask
	// Prescaled rate: one step per 2*2^n cycles, never faster
	task automatic t_rate;
		logic [31:0] a, b;
		int ta, span;
		for (int n = 0; n < 3; n++)
		begin
			wb_wr(`OFS_CORE_CNT, 32'h0);
			wb_wr(`OFS_CORE_CTRL, 32'(n << `CTL_PRE_LO) | 32'h1);
			wb_rd(`OFS_CORE_CNT, a);
			ta = t_ack;
			repeat (64) @(posedge clk_sys);
			wb_rd(`OFS_CORE_CNT, b);
			span = (t_ack - ta) / (2 << n);
			check({31'h0, int'(b - a) + 1 >= span && int'(b - a) <= span + 1}, 32'h1, "rate");
			wb_wr(`OFS_CORE_CTRL, 32'h0);
		end
	endtask
	// Software direction, then the pin inverts it
	task automatic t_dir;
		logic [31:0] a, b;
		wb_wr(`OFS_CORE_CNT, 32'h8000);
		wb_wr(`OFS_CORE_CTRL, 32'h3);
		repeat (20) @(posedge clk_sys);
		wb_rd(`OFS_CORE_CNT, a);
		check({31'h0, a < 32'h8000 && a > 32'h7fe0}, 32'h1, "count down");
		pin_toggle(`PIN_CORE_DIR);
		wb_wr(`OFS_CORE_CTRL, 32'h7);
		wb_rd(`OFS_CORE_CNT, a);
		repeat (20) @(posedge clk_sys);
		wb_rd(`OFS_CORE_CNT, b);
		check({31'h0, b > a}, 32'h1, "pin turns up");
		pin_toggle(`PIN_CORE_DIR);
		wb_wr(`OFS_CORE_CTRL, 32'h0);
	endtask
	// Core wrap: reload, latch, latch-clocked aux, export pulse, interrupt
	task automatic t_wrap;
		logic [31:0] a;
		int n;
		wb_wr(`OFS_AUX_CNT, 32'h0);
		wb_wr(`OFS_AUX_CTRL, 32'h11);
		wb_wr(`OFS_CAPTURE_RELOAD_REG, 32'h1234);
		wb_wr(`OFS_MASK, 32'h2);
		wb_wr(`OFS_CORE_CNT, 32'hfffe);
		wb_wr(`OFS_CORE_CTRL, 32'h301);
		n = 0;
		while (o_core_wrap_event !== 1'b1 && n < 40)
		begin
			@(posedge clk_sys);
			n++;
		end
		check({31'h0, n < 40}, 32'h1, "wrap event");
		if (n >= 40)
		begin
			report_and_stop();
		end
		repeat (3) @(posedge clk_sys);
		check({31'h0, o_toggle_out_pin}, 32'h1, "latch on pin");
		check({31'h0, o_irq}, 32'h1, "irq raised");
		wb_rd(`OFS_CORE_CNT, a);
		check({31'h0, a >= 32'h1234 && a < 32'h1240}, 32'h1, "reload");
		wb_rd(`OFS_AUX_CNT, a);
		check(a, 32'h1, "aux on latch");
		wb_rd(`OFS_STATUS, a);
		check(a, 32'h2, "core wrap flag");
		wb_wr(`OFS_STATUS, 32'h2);
		@(posedge clk_sys);
		check({31'h0, o_irq}, 32'h0, "irq cleared");
		wb_wr(`OFS_CORE_CTRL, 32'h0);
		wb_wr(`OFS_AUX_CTRL, 32'h0);
	endtask
	// External events up, then pin-reversed direction
	task automatic t_ext;
		logic [31:0] a;
		wb_wr(`OFS_AUX_CNT, 32'h0);
		wb_wr(`OFS_AUX_CTRL, 32'h09);
		repeat (6) pin_toggle(`PIN_AUX_CNT);
		wb_rd(`OFS_AUX_CNT, a);
		check(a, 32'h3, "external count");
		pin_toggle(`PIN_AUX_DIR);
		wb_wr(`OFS_AUX_CTRL, 32'h0d);
		repeat (4) pin_toggle(`PIN_AUX_CNT);
		wb_rd(`OFS_AUX_CNT, a);
		check(a, 32'h1, "aux pin direction");
		pin_toggle(`PIN_AUX_DIR);
		wb_wr(`OFS_AUX_CTRL, 32'h0);
		// Core timer on its own count pin
		wb_wr(`OFS_CORE_CNT, 32'h0);
		wb_wr(`OFS_CORE_CTRL, 32'h09);
		repeat (4) pin_toggle(`PIN_CORE_CNT);
		wb_rd(`OFS_CORE_CNT, a);
		check(a, 32'h2, "core external count");
		wb_wr(`OFS_CORE_CTRL, 32'h0);
		// Aux on the prescaler, counting down from zero, must wrap at once
		wb_wr(`OFS_AUX_CNT, 32'h0);
		wb_wr(`OFS_AUX_CTRL, 32'h03);
		repeat (4) @(posedge clk_sys);
		wb_wr(`OFS_AUX_CTRL, 32'h0);
		wb_rd(`OFS_STATUS, a);
		check(a, 32'h1, "aux wrap flag");
		wb_wr(`OFS_STATUS, 32'h1);
	endtask
	// Capture sources and edges; aux stopped so its value is known
	task automatic t_cap;
		cap_case_t tbl [11] = '{
			'{CAP_PIN, EDGE_RISE, `PIN_CAPTURE_IN_PIN, 1'b1, 1'b1},
			'{CAP_PIN, EDGE_RISE, `PIN_CAPTURE_IN_PIN, 1'b0, 1'b1},
			'{CAP_PIN, EDGE_FALL, `PIN_CAPTURE_IN_PIN, 1'b0, 1'b0},
			'{CAP_PIN, EDGE_FALL, `PIN_CAPTURE_IN_PIN, 1'b1, 1'b0},
			'{CAP_PIN, EDGE_NONE, `PIN_CAPTURE_IN_PIN, 1'b0, 1'b1},
			'{CAP_PIN, EDGE_BOTH, `PIN_CAPTURE_IN_PIN, 1'b1, 1'b1},
			'{CAP_PEER_CNT, EDGE_BOTH, `PIN_PEER_CNT, 1'b1, 1'b1},
			'{CAP_PEER_DIR, EDGE_BOTH, `PIN_PEER_CNT, 1'b0, 1'b1},
			'{CAP_PEER_DIR, EDGE_BOTH, `PIN_PEER_DIR, 1'b1, 1'b1},
			'{CAP_PEER_BOTH, EDGE_BOTH, `PIN_PEER_CNT, 1'b1, 1'b1},
			'{CAP_PEER_BOTH, EDGE_BOTH, `PIN_PEER_DIR, 1'b1, 1'b0}};
		logic [31:0] a, v;
		for (int i = 0; i < 11; i++)
		begin
			v = 32'h0100 + 32'(i);
			wb_wr(`OFS_CAPTURE_RELOAD_REG, 32'h0);
			wb_wr(`OFS_AUX_CNT, v);
			wb_wr(`OFS_AUX_CTRL, {19'h0, tbl[i].edg, tbl[i].src, tbl[i].clr, 8'h00});
			pin_toggle(tbl[i].pin);
			wb_rd(`OFS_CAPTURE_RELOAD_REG, a);
			check(a, tbl[i].hit ? v : 32'h0, "capture");
			wb_rd(`OFS_AUX_CNT, a);
			check(a, (tbl[i].hit && tbl[i].clr) ? 32'h0 : v, "clear after capture");
			wb_rd(`OFS_STATUS, a);
			check(a, {29'h0, tbl[i].hit, 2'b00}, "capture flag");
			check({31'h0, o_irq}, 32'h0, "masked irq");
			wb_wr(`OFS_STATUS, 32'h4);
		end
	endtask
	// Main sequence
	initial
	begin
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		sel = 4'h0;
		toggle = '0;
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		t_map();
		t_rate();
		t_dir();
		t_wrap();
		t_ext();
		t_cap();
		report_and_stop();
	end
endmodule

// ### verification/event_source.sv
// Far-side model: count, direction, capture and peer timer pins
`timescale 1ns/10ps
`include "gpt_map.svh"
module event_source
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [`PIN_N-1:0] i_toggle,
	output logic [`PIN_N-1:0] o_pins
);
	// Levels hold between events; one request flips one pin, so every edge is clean
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_pins <= `PIN_RST;
		end
		else
		begin
			o_pins <= o_pins ^ i_toggle;
		end
	end
endmodule
